//--- shared/ta_guard_consts.svh
// constants for the timed access write guard
`ifndef TA_GUARD_CONSTS_SVH
`define TA_GUARD_CONSTS_SVH
`define TA_KEY_ADDR 8'hC7
`define TA_KEY_RESET 8'h00
`define TA_KEY_FIRST 8'hAA
`define TA_KEY_SECOND 8'h55
`define TA_KEY_WAIT_CYCLES 3
`define TA_WINDOW_CYCLES 4
`define TA_GUARD_COUNT 2
`define TA_GUARD_ADDRS {8'hAA, 8'hA3}
`define TA_GUARD_MASKS {8'hFF, 8'hFF}
`define TA_GUARD_RESETS {8'h00, 8'h00}
`endif

//--- shared/ta_guard_pkg.sv
// types shared by the timed access write guard
package ta_guard_pkg;
  // one special function register access from the core, all fields valid together
  typedef struct packed {
    logic wr;          // write strobe, one cycle
    logic rd;          // read strobe, one cycle
    logic [7:0] addr;  // register address
    logic [7:0] wdata; // write data
  } sfr_req_t;
endpackage : ta_guard_pkg

//--- hdl/timed_access_write_guard.sv
// timed access write guard with its guarded registers
`include "ta_guard_consts.svh"

module timed_access_write_guard #(
  parameter int GUARD_N = `TA_GUARD_COUNT,
  parameter logic [GUARD_N-1:0][7:0] GUARD_ADDR = `TA_GUARD_ADDRS,
  parameter logic [GUARD_N-1:0][7:0] GUARD_MASK = `TA_GUARD_MASKS,
  parameter logic [GUARD_N-1:0][7:0] GUARD_RESET = `TA_GUARD_RESETS
) (
  input wire logic clk,                           // system clock, 40 MHz
  input wire logic rstn,                          // asynchronous reset, active low
  input wire ta_guard_pkg::sfr_req_t req,         // register access from the core
  output logic [7:0] rd_data,                     // read data, valid the cycle after rd
  output logic rd_hit,                            // read hit this block, same timing as rd_data
  output logic prot_wr_en,                        // protected write window open
  output logic [GUARD_N-1:0][7:0] guard_q         // guarded register contents
);

  // ------------------------------------------------------------
  // key detection
  // ------------------------------------------------------------
  // a plain down-counter arms the second key; it needs no decode and reloads on every aa
  localparam logic [1:0] KEY_WAIT = 2'(`TA_KEY_WAIT_CYCLES);
  localparam logic [2:0] WIN_LEN = 3'(`TA_WINDOW_CYCLES);

  logic [1:0] key_cnt_ff;
  logic [2:0] win_cnt_ff;
  logic [7:0] rd_data_ff;
  logic rd_hit_ff;
  logic ta_wr;
  logic key_ok;

  // address match used by the write path and the read path
  // one decode keeps both paths from drifting apart when the map changes
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ref_a);
    addr_hit = (a == ref_a);
  endfunction : addr_hit

  assign ta_wr = req.wr && addr_hit(req.addr, `TA_KEY_ADDR);
  // second key only while the first one is still live
  assign key_ok = ta_wr && (req.wdata == `TA_KEY_SECOND) && (key_cnt_ff != 2'h0);

  // counts down the cycles that a 55 may still follow an aa; any other key value disarms
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      key_cnt_ff <= 2'h0;
    end else if (ta_wr && (req.wdata == `TA_KEY_FIRST)) begin
      key_cnt_ff <= KEY_WAIT;
    end else if (ta_wr) begin
      key_cnt_ff <= 2'h0;
    end else if (key_cnt_ff != 2'h0) begin
      key_cnt_ff <= key_cnt_ff - 2'h1;
    end
  end

  // ------------------------------------------------------------
  // write window
  // ------------------------------------------------------------
  // window runs free once opened; a new aa does not cut it short, only rearms the key
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      win_cnt_ff <= 3'h0;
    end else if (key_ok) begin
      win_cnt_ff <= WIN_LEN;
    end else if (win_cnt_ff != 3'h0) begin
      win_cnt_ff <= win_cnt_ff - 3'h1;
    end
  end

  // the window is a level, so one qualifier gates every guarded register alike
  assign prot_wr_en = (win_cnt_ff != 3'h0);

  // ------------------------------------------------------------
  // guarded registers
  // ------------------------------------------------------------
  // unprotected bits take every write; protected bits only inside the window
  // limitation: a write that misses the window is lost silently; only a read back shows it
  for (genvar gi = 0; gi < GUARD_N; gi++) begin : g_guard
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        guard_q[gi] <= GUARD_RESET[gi];
      end else if (req.wr && addr_hit(req.addr, GUARD_ADDR[gi])) begin
        if (prot_wr_en) begin
          guard_q[gi] <= req.wdata;
        end else begin
          guard_q[gi] <= (guard_q[gi] & GUARD_MASK[gi]) | (req.wdata & ~GUARD_MASK[gi]);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // reads never look at the window; the key register is write only and reads zero
  // a write in the same cycle as a read lands after it, so the read returns the old value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_ff <= 8'h00;
      rd_hit_ff <= 1'b0;
    end else begin
      rd_data_ff <= 8'h00;
      rd_hit_ff <= req.rd && addr_hit(req.addr, `TA_KEY_ADDR);
      for (int i = 0; i < GUARD_N; i++) begin
        if (req.rd && addr_hit(req.addr, GUARD_ADDR[i])) begin
          rd_data_ff <= guard_q[i];
          rd_hit_ff <= 1'b1;
        end
      end
    end
  end

  assign rd_data = rd_data_ff;
  assign rd_hit = rd_hit_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // properties below watch the request inputs as well as design-driven signals and stay quiet during reset
  // aa history, one bit per cycle back, deep enough to reach an aa three cycles before its 55
  localparam int HIST_LEN = `TA_KEY_WAIT_CYCLES + 1;
  logic [HIST_LEN-1:0] first_hist_ff;
  logic first_key;

  assign first_key = ta_wr && (req.wdata == `TA_KEY_FIRST);

  // bit 0 holds the cycle before, the top bit the oldest aa that may still arm a 55
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      first_hist_ff <= '0;
    end else begin
      first_hist_ff <= {first_hist_ff[HIST_LEN-2:0], first_key};
    end
  end

  AST_PAIR_OPENS: assert property (@(posedge clk) disable iff (!rstn)
    (ta_wr && req.wdata == `TA_KEY_FIRST) ##1 (ta_wr && req.wdata == `TA_KEY_SECOND) |=> prot_wr_en)
    else $error("key pair back to back did not open the window");

  AST_SECOND_IN_TIME: assert property (@(posedge clk) disable iff (!rstn)
    first_key ##1 (!ta_wr) [*2] ##1 (ta_wr && req.wdata == `TA_KEY_SECOND) |=> prot_wr_en)
    else $error("second key three cycles after first was refused");

  AST_LATE_SECOND: assert property (@(posedge clk) disable iff (!rstn)
    (ta_wr && req.wdata == `TA_KEY_FIRST) ##1 (!ta_wr) [*3] ##1 (ta_wr && req.wdata == `TA_KEY_SECOND)
      && !prot_wr_en |=> !prot_wr_en)
    else $error("late second key opened the window");

  AST_WINDOW_LEN: assert property (@(posedge clk) disable iff (!rstn)
    key_ok |=> prot_wr_en [*4])
    else $error("window closed before four cycles");

  AST_CLOSED_KEEPS: assert property (@(posedge clk) disable iff (!rstn)
    (!prot_wr_en && req.wr && addr_hit(req.addr, GUARD_ADDR[0]))
      |=> ((guard_q[0] & GUARD_MASK[0]) == ($past(guard_q[0]) & GUARD_MASK[0])))
    else $error("protected bits changed outside the window");

  AST_OPEN_TAKES: assert property (@(posedge clk) disable iff (!rstn)
    (prot_wr_en && req.wr && addr_hit(req.addr, GUARD_ADDR[0])) |=> (guard_q[0] == $past(req.wdata)))
    else $error("write inside the window was lost");

  AST_AFTER_CLOSE: assert property (@(posedge clk) disable iff (!rstn)
    $fell(prot_wr_en) && !key_ok && req.wr && addr_hit(req.addr, GUARD_ADDR[0])
      |=> ((guard_q[0] & GUARD_MASK[0]) == ($past(guard_q[0]) & GUARD_MASK[0])))
    else $error("write just after window close changed protected bits");

  AST_READ_ANYTIME: assert property (@(posedge clk) disable iff (!rstn)
    (req.rd && addr_hit(req.addr, GUARD_ADDR[0])) |=> (rd_hit && rd_data == $past(guard_q[0])))
    else $error("guarded register read did not return its value");

  AST_OPEN_CAUSE: assert property (@(posedge clk) disable iff (!rstn)
    $rose(prot_wr_en) |-> $past(key_ok) && (|first_hist_ff[HIST_LEN-1:1]))
    else $error("window opened without a preceding key pair");

  AST_WINDOW_CLOSE: assert property (@(posedge clk) disable iff (!rstn)
    key_ok ##1 (!key_ok) [*4] |=> !prot_wr_en)
    else $error("window stayed open past four cycles");

  AST_UNARMED_SECOND: assert property (@(posedge clk) disable iff (!rstn)
    (ta_wr && req.wdata == `TA_KEY_SECOND && key_cnt_ff == 2'h0 && !prot_wr_en) |=> !prot_wr_en)
    else $error("second key without a live first key opened the window");

  AST_FIRST_REARMS: assert property (@(posedge clk) disable iff (!rstn)
    first_key |=> (key_cnt_ff == KEY_WAIT))
    else $error("first key did not restart key detection");

  AST_FREE_BITS: assert property (@(posedge clk) disable iff (!rstn)
    (req.wr && addr_hit(req.addr, GUARD_ADDR[0]))
      |=> ((guard_q[0] & ~GUARD_MASK[0]) == ($past(req.wdata) & ~GUARD_MASK[0])))
    else $error("unprotected bits did not take the write");

  AST_KEY_READS_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    (req.rd && addr_hit(req.addr, `TA_KEY_ADDR)) |=> (rd_hit && rd_data == 8'h00))
    else $error("key register read did not return zero");

  AST_IDLE_READ: assert property (@(posedge clk) disable iff (!rstn)
    !req.rd |=> (!rd_hit && rd_data == 8'h00))
    else $error("read answer appeared without a read");

  // every guarded register, not only the first, answers reads and keeps its locked bits
  for (genvar ci = 0; ci < GUARD_N; ci++) begin : g_guard_chk
    AST_READ_EACH: assert property (@(posedge clk) disable iff (!rstn)
      (req.rd && addr_hit(req.addr, GUARD_ADDR[ci])) |=> (rd_hit && rd_data == $past(guard_q[ci])))
      else $error("read of a guarded register returned a stale value");
    AST_CLOSED_EACH: assert property (@(posedge clk) disable iff (!rstn)
      (!prot_wr_en && req.wr && addr_hit(req.addr, GUARD_ADDR[ci]))
        |=> ((guard_q[ci] & GUARD_MASK[ci]) == ($past(guard_q[ci]) & GUARD_MASK[ci])))
      else $error("protected bits of a guarded register changed while locked");
  end

endmodule : timed_access_write_guard

//--- tb/core_sfr_model.sv
// core side model issuing register accesses to the guard
`include "ta_guard_consts.svh"
module core_sfr_model (
  input wire logic clk, // system clock
  output ta_guard_pkg::sfr_req_t req // access toward the guard
);
  timeunit 1ns;
  timeprecision 100ps;
  initial req = '0;
  // one access per cycle, launched 1 ns after the edge so the bus is settled when sampled
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    #1;
  endtask : put
  // idle cycles: lines stop holding the last value, so stale data cannot pass
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      req = '{wr: 1'b0, rd: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
      @(posedge clk);
      #1;
    end
  endtask : idle
  // key pair back to back, as interrupt-masked code does, before each protected write
  task automatic unlock();
    put(1'b1, `TA_KEY_ADDR, `TA_KEY_FIRST);
    put(1'b1, `TA_KEY_ADDR, `TA_KEY_SECOND);
  endtask : unlock
endmodule : core_sfr_model

//--- tb/tb_timed_access_write_guard.sv
// self-checking testbench for the timed access write guard
`include "ta_guard_consts.svh"
module tb_timed_access_write_guard;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [1:0][7:0] GA = `TA_GUARD_ADDRS;
  // mixed mask and a non-zero reset so the free-bit path and reset loading are both seen
  localparam logic [1:0][7:0] GM = {8'hFF, 8'hF0};
  localparam logic [1:0][7:0] GR = {8'h81, 8'h00};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  ta_guard_pkg::sfr_req_t req;
  logic [7:0] rd_data;
  logic rd_hit;
  logic prot_wr_en;
  logic [1:0][7:0] guard_q;
  int n_errors = 0;
  int n_tests = 0;
  int cnt;
  always #12.5 clk = ~clk;
  core_sfr_model cpu (.clk(clk), .req(req));
  timed_access_write_guard #(.GUARD_MASK(GM), .GUARD_RESET(GR))
    uut (.clk(clk), .rstn(rstn), .req(req), .rd_data(rd_data), .rd_hit(rd_hit),
    .prot_wr_en(prot_wr_en), .guard_q(guard_q));
  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // read one place; the answer is registered, so look one edge later
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    cpu.put(1'b0, a, 8'h00);
    chk("rd_data", exp, rd_data);
    chk("rd_hit", {7'h00, hit}, {7'h00, rd_hit});
  endtask : rd_chk
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  // reads need no key; unmapped place gives no hit
  task automatic t_reads();
    rd_chk(GA[0], 8'h00, 1'b1);
    rd_chk(GA[1], 8'h81, 1'b1);
    rd_chk(`TA_KEY_ADDR, 8'h00, 1'b1);
    rd_chk(8'h00, 8'h00, 1'b0);
  endtask : t_reads
  // locked writes, lone second key, then a proper unlock
  task automatic t_basic();
    cpu.put(1'b1, GA[0], 8'h3C);
    chk("locked", 8'h0C, guard_q[0]);
    cpu.put(1'b1, `TA_KEY_ADDR, `TA_KEY_SECOND);
    cpu.put(1'b1, GA[0], 8'h3C);
    chk("no_first", 8'h0C, guard_q[0]);
    cpu.unlock();
    cpu.put(1'b1, GA[0], 8'h5A);
    chk("open", 8'h5A, guard_q[0]);
    rd_chk(GA[0], 8'h5A, 1'b1);
    cpu.idle(4);
  endtask : t_basic
  // second key one cycle too late, then at the last allowed cycle
  task automatic t_late();
    cpu.put(1'b1, `TA_KEY_ADDR, `TA_KEY_FIRST);
    cpu.idle(3);
    cpu.put(1'b1, `TA_KEY_ADDR, `TA_KEY_SECOND);
    cpu.put(1'b1, GA[1], 8'h96);
    chk("late", 8'h81, guard_q[1]);
    cpu.put(1'b1, `TA_KEY_ADDR, `TA_KEY_FIRST);
    cpu.idle(2);
    cpu.put(1'b1, `TA_KEY_ADDR, `TA_KEY_SECOND);
    cpu.put(1'b1, GA[1], 8'h96);
    chk("last_ok", 8'h96, guard_q[1]);
    cpu.idle(5);
  endtask : t_late
  // window length, last cycle inside and first cycle outside
  task automatic t_window();
    cnt = 0;
    cpu.unlock();
    repeat (6) begin
      cnt += (prot_wr_en === 1'b1);
      cpu.idle(1);
    end
    chk("window", 8'(`TA_WINDOW_CYCLES), cnt[7:0]);
    cpu.unlock();
    rd_chk(GA[1], 8'h96, 1'b1);
    cpu.idle(2);
    cpu.put(1'b1, GA[1], 8'hC3);
    cpu.put(1'b1, GA[0], 8'h11);
    chk("in_win", 8'hC3, guard_q[1]);
    chk("closed", 8'h51, guard_q[0]);
    cpu.idle(1);
  endtask : t_window
  // a wrong key disarms; a fresh first key restarts detection, so a 55 late for
  // the first aa but in time for the second one still opens
  task automatic t_restart();
    cpu.put(1'b1, `TA_KEY_ADDR, `TA_KEY_FIRST);
    cpu.put(1'b1, `TA_KEY_ADDR, 8'h12);
    cpu.put(1'b1, `TA_KEY_ADDR, `TA_KEY_SECOND);
    cpu.put(1'b1, GA[0], 8'hFF);
    chk("disarm", 8'h5F, guard_q[0]);
    cpu.put(1'b1, `TA_KEY_ADDR, `TA_KEY_FIRST);
    cpu.idle(2);
    cpu.put(1'b1, `TA_KEY_ADDR, `TA_KEY_FIRST);
    cpu.idle(2);
    cpu.put(1'b1, `TA_KEY_ADDR, `TA_KEY_SECOND);
    cpu.put(1'b1, GA[0], 8'h0F);
    chk("rearm", 8'h0F, guard_q[0]);
  endtask : t_restart
  // main sequence: reset for three cycles, then the scenarios
  initial begin
    repeat (3) @(posedge clk);
    #1 rstn = 1'b1;
    t_reads();
    t_basic();
    t_late();
    t_window();
    t_restart();
    stop_test();
  end
  // watchdog: the run needs well under 100 cycles
  initial begin
    #20000;
    n_errors++;
    stop_test();
  end
endmodule : tb_timed_access_write_guard
